// ### core/wfd_pkg.sv
// constants and helpers shared by the wake frame and magic packet detector
package wfd_pkg;
    localparam int WFD_NFILT = 4;
    localparam int WFD_MASK_W = 31;
    localparam int WFD_STORE_WORDS = 8;
    // register byte offsets
    localparam logic [7:0] WFD_CSR_OFS = 8'h00;
    localparam logic [7:0] WFD_STORE_OFS = 8'h04;
    localparam logic [7:0] WFD_INFO_OFS = 8'h08;
    // wake_control_status fields
    localparam int WFD_MAGIC_DETECT_ENABLE_BIT = 1;
    localparam int WFD_WFEN_BIT = 2;
    localparam int WFD_MIRQ_BIT = 3;
    localparam int WFD_MREC_BIT = 4;
    localparam int WFD_WREC_BIT = 5;
    localparam int WFD_GUEN_BIT = 9;
    localparam logic [31:0] WFD_CSR_WMASK = 32'h0000_020e;
    localparam logic [31:0] WFD_CSR_RST = 32'h0000_0000;
    localparam logic [31:0] WFD_STORE_RST = 32'h0000_0000;
    // wake_pattern_store word layout
    localparam logic [2:0] WFD_W_MASK0 = 3'h0;
    localparam logic [2:0] WFD_W_CMD = 3'h4;
    localparam logic [2:0] WFD_W_OFS = 3'h5;
    localparam logic [2:0] WFD_W_CRC01 = 3'h6;
    localparam logic [2:0] WFD_W_CRC23 = 3'h7;
    localparam int WFD_CMD_EN_BIT = 0;
    localparam int WFD_CMD_ATYPE_BIT = 3;
    localparam int WFD_CMD_STRIDE = 8;
    // frame layout
    localparam logic [8:0] WFD_DA_LEN = 9'h006;
    localparam logic [8:0] WFD_HDR_LEN = 9'h00c;
    localparam logic [2:0] WFD_SYNC_LEN = 3'h6;
    localparam logic [2:0] WFD_ADDR_LAST = 3'h5;
    localparam logic [3:0] WFD_REP_LAST = 4'hf;
    localparam logic [7:0] WFD_SYNC_BYTE = 8'hff;
    // crc-16, reflected form, one byte at a time
    localparam logic [15:0] WFD_CRC_INIT = 16'hffff;
    localparam logic [15:0] WFD_CRC_POLY = 16'ha001;

    function automatic logic [15:0] wfd_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int b = 0; b < 8; b++) begin
            r = r[0] ? ((r >> 1) ^ WFD_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : wfd_crc_byte
endpackage : wfd_pkg

// ### core/wfd_filter.sv
// one wake pattern filter: masked byte selection and running crc-16
`timescale 1ns/10ps
`default_nettype none
module wfd_filter
    import wfd_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rstn_i, // async reset, low
    input wire logic ce_i, // clock enable
    input wire logic sof_i, // first byte of frame
    input wire logic valid_i, // byte strobe
    input wire logic [7:0] data_i, // frame byte
    input wire logic [8:0] idx_i, // byte index in frame
    input wire logic [30:0] mask_i, // byte mask
    input wire logic [7:0] offset_i, // pattern offset
    input wire logic [15:0] exp_crc_i, // expected crc
    output logic match_o // crc equals expected
);
    logic [15:0] crc_q;
    logic [15:0] base;
    logic [8:0] rel;
    logic take;

    always_comb begin
        rel = idx_i - {1'b0, offset_i};
        take = valid_i && (idx_i >= {1'b0, offset_i}) && (rel < 9'(WFD_MASK_W))
               && mask_i[rel[4:0]];
        base = sof_i ? WFD_CRC_INIT : crc_q;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            crc_q <= WFD_CRC_INIT;
        end else if (ce_i) begin
            if (take) begin
                crc_q <= wfd_crc_byte(base, data_i);
            end else if (sof_i) begin
                crc_q <= WFD_CRC_INIT;
            end
        end
    end

    assign match_o = (crc_q == exp_crc_i);
endmodule : wfd_filter
`default_nettype wire

// ### core/wfd_magic.sv
// magic packet scanner: sync stream then sixteen station address copies
`timescale 1ns/10ps
`default_nettype none
module wfd_magic
    import wfd_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rstn_i, // async reset, low
    input wire logic ce_i, // clock enable
    input wire logic sof_i, // first byte of frame
    input wire logic valid_i, // byte strobe
    input wire logic [7:0] data_i, // frame byte
    input wire logic [8:0] idx_i, // byte index in frame
    input wire logic [47:0] station_i, // station address
    output logic found_o // pattern seen in this frame
);
    typedef enum logic {MG_SYNC, MG_REP} wfd_mg_t;
    wfd_mg_t st_q;
    logic [2:0] ff_q;
    logic [2:0] pos_q;
    logic [3:0] rep_q;
    logic [7:0] exp_b;
    logic [7:0] first_b;
    logic is_ff;

    always_comb begin
        exp_b = station_i[47 - 8 * pos_q -: 8];
        first_b = station_i[47:40];
        is_ff = (data_i == WFD_SYNC_BYTE);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= MG_SYNC;
            ff_q <= 3'h0;
            pos_q <= 3'h0;
            rep_q <= 4'h0;
            found_o <= 1'b0;
        end else if (ce_i) begin
            if (sof_i) begin
                st_q <= MG_SYNC;
                ff_q <= 3'h0;
                pos_q <= 3'h0;
                rep_q <= 4'h0;
                found_o <= 1'b0;
            end else if (valid_i && idx_i >= WFD_HDR_LEN && !found_o) begin
                case (st_q)
                    MG_SYNC: begin
                        if (ff_q == WFD_SYNC_LEN && data_i == first_b) begin
                            st_q <= MG_REP;
                            pos_q <= 3'h1;
                            rep_q <= 4'h0;
                        end else if (is_ff) begin
                            ff_q <= (ff_q == WFD_SYNC_LEN) ? ff_q : ff_q + 3'h1;
                        end else begin
                            ff_q <= 3'h0;
                        end
                    end
                    MG_REP: begin
                        if (data_i == exp_b) begin
                            if (pos_q == WFD_ADDR_LAST) begin
                                pos_q <= 3'h0;
                                rep_q <= rep_q + 4'h1;
                                if (rep_q == WFD_REP_LAST) begin
                                    found_o <= 1'b1;
                                    st_q <= MG_SYNC;
                                end
                            end else begin
                                pos_q <= pos_q + 3'h1;
                            end
                        end else begin
                            st_q <= MG_SYNC;
                            ff_q <= is_ff ? 3'h1 : 3'h0;
                            pos_q <= 3'h0;
                        end
                    end
                    default: st_q <= MG_SYNC;
                endcase
            end
        end
    end
endmodule : wfd_magic
`default_nettype wire

// ### core/wfd_top.sv
// wake frame and magic packet detector with ahb-lite registers
// Functional notes
// - only bytes at offset+j with mask bit j set enter the filter crc
// - command bit 3 picks multicast (1) or unicast (0) patterns
// - command bit 0 enables a filter; disabled filters never wake
// - 8-bit pattern offset; offset zero is first destination address byte
// - 16-bit expected crc equal to computed crc is a pattern match
// - broadcast frame wakes on any enabled crc match, other terms ignored
// - unicast crc match wakes when global unicast enable bit 9 set
// - with address filter pass: multicast and type 1, or unicast and type 0
// - magic enable stops normal delivery and starts magic scanning
// - magic hit sets magic_received and optionally a wake event
// - clearing magic enable resumes normal reception only while wake enable is also clear
// - magic scan accepts own station or broadcast destination
// - multicast destination also accepted for magic detection
// - six all-ones sync bytes searched after both address fields
// - sixteen unbroken station address copies after sync declare magic
// - broken repetitions send the scanner back to sync search
// - sync may start anywhere; copies count only right after sync
// - magic detection works in every power state
// - wake enable suppresses reception; match sets flag and wake event
// - clearing wake enable resumes ordinary reception only while magic enable is also clear
`timescale 1ns/10ps
`default_nettype none
module wfd_top
    import wfd_pkg::*;
(
    input wire logic clk_i, // 250 MHz clock
    input wire logic rstn_i, // async reset, low
    input wire logic ce_i, // clock enable, freezes state when low
    input wire logic hsel_i, // ahb select
    input wire logic [31:0] haddr_i, // ahb address
    input wire logic [1:0] htrans_i, // ahb transfer type
    input wire logic hwrite_i, // ahb write
    input wire logic [2:0] hsize_i, // ahb size, word only
    input wire logic [31:0] hwdata_i, // ahb write data
    input wire logic hready_i, // ahb bus ready
    output logic [31:0] hrdata_o, // ahb read data
    output logic hreadyout_o, // ahb slave ready
    output logic hresp_o, // ahb response, always okay
    input wire logic rx_sof_i, // first byte of frame
    input wire logic rx_valid_i, // received byte strobe
    input wire logic [7:0] rx_data_i, // received byte
    input wire logic rx_eof_i, // frame end pulse, after last byte
    input wire logic rx_fcs_ok_i, // frame check passed, with eof
    input wire logic rx_addr_pass_i, // regular address filter pass, with eof
    input wire logic [47:0] station_addr_i, // station address, first byte in 47:40
    output logic rx_deliver_en_o, // normal reception allowed
    output logic wake_event_o // wake event pulse to interrupt controller
);
    logic [31:0] csr_q;
    logic [31:0] store_q [WFD_STORE_WORDS];
    logic [2:0] ptr_q;
    logic [WFD_NFILT-1:0] hit_q;
    logic [8:0] idx_q;
    logic [8:0] idx;
    logic [47:0] da_q;
    logic wr_q;
    logic [7:0] wa_q;
    logic acc;
    logic [WFD_NFILT-1:0] fmatch;
    logic [WFD_NFILT-1:0] fwake;
    logic magic_found;
    logic bcast;
    logic mcast;
    logic ucast;
    logic own;
    logic magic_hit;
    logic wf_hit;
    logic mrec_set;
    logic wrec_set;
    logic mrec_clr;
    logic wrec_clr;
    logic wake_en;
    logic magic_en;

    // ---------------- ahb-lite slave, zero wait states
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign acc = hsel_i && htrans_i[1] && hready_i;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
        end else if (ce_i) begin
            wr_q <= acc && hwrite_i;
            wa_q <= haddr_i[7:0];
        end
    end

    // read data registered at the address phase so it stands in the data phase
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            if (acc && !hwrite_i) begin
                case (haddr_i[7:0])
                    WFD_CSR_OFS: hrdata_o <= csr_q;
                    WFD_STORE_OFS: hrdata_o <= store_q[ptr_q];
                    WFD_INFO_OFS: hrdata_o <= {20'h00000, hit_q, 5'h00, ptr_q};
                    default: hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------- wake_control_status
    assign magic_en = csr_q[WFD_MAGIC_DETECT_ENABLE_BIT];
    assign wake_en = csr_q[WFD_WFEN_BIT];
    // status bits clear on writing one; a hardware set in the same cycle wins
    assign mrec_clr = wr_q && wa_q == WFD_CSR_OFS && hwdata_i[WFD_MREC_BIT];
    assign wrec_clr = wr_q && wa_q == WFD_CSR_OFS && hwdata_i[WFD_WREC_BIT];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            csr_q <= WFD_CSR_RST;
        end else if (ce_i) begin
            if (wr_q && wa_q == WFD_CSR_OFS) begin
                csr_q <= (csr_q & ~WFD_CSR_WMASK) | (hwdata_i & WFD_CSR_WMASK);
            end
            csr_q[WFD_MREC_BIT] <= mrec_set || (csr_q[WFD_MREC_BIT] && !mrec_clr);
            csr_q[WFD_WREC_BIT] <= wrec_set || (csr_q[WFD_WREC_BIT] && !wrec_clr);
        end
    end

    // ---------------- wake_pattern_store: one location, pointer walks eight words
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr_q <= 3'h0;
            for (int w = 0; w < WFD_STORE_WORDS; w++) begin
                store_q[w] <= WFD_STORE_RST;
            end
        end else if (ce_i) begin
            if (wr_q && wa_q == WFD_STORE_OFS) begin
                store_q[ptr_q] <= hwdata_i;
                ptr_q <= ptr_q + 3'h1;
            end
        end
    end

    // ---------------- receive byte tracking
    assign idx = rx_sof_i ? 9'h000 : idx_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            idx_q <= 9'h000;
            da_q <= 48'h0;
        end else if (ce_i) begin
            if (rx_valid_i || rx_sof_i) begin
                idx_q <= (idx == 9'h1ff) ? idx : idx + 9'h001;
            end
            if (rx_valid_i && idx < WFD_DA_LEN) begin
                da_q <= {da_q[39:0], rx_data_i};
            end
        end
    end

    assign bcast = (da_q == 48'hffff_ffff_ffff);
    assign mcast = da_q[40] && !bcast;
    assign ucast = !da_q[40];
    assign own = (da_q == station_addr_i);

    // ---------------- pattern filters
    for (genvar f = 0; f < WFD_NFILT; f++) begin : g_filt
        logic [3:0] cmd;
        logic [15:0] exp_crc;
        assign cmd = store_q[WFD_W_CMD][f*WFD_CMD_STRIDE +: 4];
        assign exp_crc = store_q[WFD_W_CRC01 + 3'(f / 2)][(f % 2)*16 +: 16];

        wfd_filter u_filt (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .ce_i(ce_i),
            .sof_i(rx_sof_i),
            .valid_i(rx_valid_i && wake_en),
            .data_i(rx_data_i),
            .idx_i(idx),
            .mask_i(store_q[WFD_W_MASK0 + 3'(f)][WFD_MASK_W-1:0]),
            .offset_i(store_q[WFD_W_OFS][f*8 +: 8]),
            .exp_crc_i(exp_crc),
            .match_o(fmatch[f])
        );

        assign fwake[f] = cmd[WFD_CMD_EN_BIT] && fmatch[f]
            && (bcast
                || (ucast && csr_q[WFD_GUEN_BIT])
                || (rx_addr_pass_i && (cmd[WFD_CMD_ATYPE_BIT] ? mcast : ucast)));
    end

    // ---------------- magic packet scanner, not gated by any power state
    wfd_magic u_magic (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .sof_i(rx_sof_i),
        .valid_i(rx_valid_i && magic_en),
        .data_i(rx_data_i),
        .idx_i(idx),
        .station_i(station_addr_i),
        .found_o(magic_found)
    );

    // ---------------- end of frame decision
    assign wf_hit = wake_en && rx_eof_i && rx_fcs_ok_i && (|fwake);
    assign magic_hit = magic_en && rx_eof_i && rx_fcs_ok_i && magic_found
        && (own || bcast || mcast);
    assign mrec_set = magic_hit;
    assign wrec_set = wf_hit;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_event_o <= 1'b0;
            hit_q <= '0;
        end else if (ce_i) begin
            wake_event_o <= wf_hit || (magic_hit && csr_q[WFD_MIRQ_BIT]);
            if (wf_hit) begin
                hit_q <= fwake;
            end
        end
    end

    // either detection mode holds back normal delivery
    assign rx_deliver_en_o = !(magic_en || wake_en);
endmodule : wfd_top
`default_nettype wire

// ### tb/wfd_top_sva.sv
// assertion checker bound to the wake detector top
`timescale 1ns/10ps
`default_nettype none
module wfd_top_sva (
    input wire logic clk_i, // clock
    input wire logic rstn_i, // reset, low
    input wire logic hsel_i, // select
    input wire logic [31:0] haddr_i, // address
    input wire logic [1:0] htrans_i, // transfer type
    input wire logic hwrite_i, // write
    input wire logic [31:0] hwdata_i, // write data
    input wire logic hready_i, // bus ready
    input wire logic [31:0] hrdata_o, // read data
    input wire logic hreadyout_o, // slave ready
    input wire logic hresp_o, // response
    input wire logic rx_valid_i, // byte strobe
    input wire logic rx_eof_i, // frame end
    input wire logic rx_fcs_ok_i, // fcs good
    input wire logic rx_deliver_en_o, // delivery allowed
    input wire logic wake_event_o // wake pulse
);
    logic take_w;
    logic csr_a;
    logic wr_q;
    logic [31:0] sh_q;
    assign take_w = hsel_i && htrans_i[1] && hready_i;
    assign csr_a = haddr_i[7:0] == 8'h00;
    // shadow of the rw control bits; status bits left out as they are w1c
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= take_w && hwrite_i && csr_a;
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_q <= 32'h0000_0000;
        end else if (wr_q) begin
            sh_q <= hwdata_i & 32'h0000_020e;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_bus_okay:
        assert property (hreadyout_o && !hresp_o) else $error("bus not ready or not okay");
    a_deliver_gate:
        assert property (rx_deliver_en_o == !(sh_q[1] || sh_q[2]))
        else $error("delivery enable disagrees with detect modes");
    a_wake_after_eof:
        assert property (wake_event_o |-> $past(rx_eof_i) && !$past(rx_valid_i))
        else $error("wake not one cycle after frame end");
    a_wake_good_fcs:
        assert property (wake_event_o |-> $past(rx_fcs_ok_i)) else $error("wake on bad fcs");
    a_wake_enabled:
        assert property (wake_event_o |-> $past(sh_q[2]) || ($past(sh_q[1]) && $past(sh_q[3])))
        else $error("wake without enabled source");
    a_wake_pulse:
        assert property (wake_event_o |=> !wake_event_o) else $error("wake longer than a cycle");
    a_rdata_hold:
        assert property (!$past(take_w && !hwrite_i) |-> $stable(hrdata_o))
        else $error("read data moved without a read");
    a_csr_readback:
        assert property (take_w && !hwrite_i && csr_a |=> (hrdata_o & 32'h0000_020e) == $past(sh_q))
        else $error("control bits read back wrong");
endmodule : wfd_top_sva
bind wfd_top wfd_top_sva i_sva (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .rx_valid_i(rx_valid_i), .rx_eof_i(rx_eof_i), .rx_fcs_ok_i(rx_fcs_ok_i),
    .rx_deliver_en_o(rx_deliver_en_o), .wake_event_o(wake_event_o));
`default_nettype wire

// ### tb/wfd_rx_model.sv
// receive datapath model: plays a stored frame into the detector
`timescale 1ns/10ps
`default_nettype none
module wfd_rx_model (
    input wire logic clk_i, // clock
    output logic rx_sof_o, // first byte
    output logic rx_valid_o, // byte strobe
    output logic [7:0] rx_data_o, // byte
    output logic rx_eof_o, // end pulse
    output logic rx_fcs_ok_o, // fcs result
    output logic rx_addr_pass_o // filter result
);
    logic [7:0] fb [512];
    initial begin
        rx_sof_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        rx_eof_o = 1'b0;
        rx_fcs_ok_o = 1'b0;
        rx_addr_pass_o = 1'b0;
    end
    // slow mode leaves an idle cycle after each byte, data scrambled meanwhile
    task automatic send(input int n, input logic fcs, input logic pass, input logic slow);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rx_sof_o <= (i == 0);
            rx_valid_o <= 1'b1;
            rx_data_o <= fb[i];
            if (slow) begin
                @(posedge clk_i);
                rx_sof_o <= 1'b0;
                rx_valid_o <= 1'b0;
                rx_data_o <= ~fb[i];
            end
        end
        @(posedge clk_i);
        rx_sof_o <= 1'b0;
        rx_valid_o <= 1'b0;
        rx_data_o <= ~fb[n-1];
        rx_eof_o <= 1'b1;
        rx_fcs_ok_o <= fcs;
        rx_addr_pass_o <= pass;
        @(posedge clk_i);
        rx_eof_o <= 1'b0;
        rx_fcs_ok_o <= ~fcs;
        rx_addr_pass_o <= ~pass;
        rx_data_o <= fb[n-1];
    endtask : send
endmodule : wfd_rx_model
`default_nettype wire

// ### tb/tb_top.sv
// testbench for the wake frame and magic packet detector
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import wfd_pkg::*;
    localparam logic [47:0] STA = 48'h0211_2233_4455;
    localparam logic [47:0] BC = 48'hffff_ffff_ffff;
    localparam logic [47:0] MC = 48'h0100_5e00_0001;
    localparam logic [30:0] MASK = 31'h4000_0505;
    logic clk_i = 1'b0, rstn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
    logic [1:0] htrans_i = 2'h0;
    logic hreadyout_o, hresp_o, sof, vld, eof, fok, apass, deliver, wake;
    logic [7:0] rxd;
    logic [15:0] ecrc;
    int failures = 0, comparisons = 0, wakes = 0, wp = 0;
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (wake === 1'b1) wakes++;
    wfd_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rx_sof_i(sof), .rx_valid_i(vld),
        .rx_data_i(rxd), .rx_eof_i(eof), .rx_fcs_ok_i(fok), .rx_addr_pass_i(apass),
        .station_addr_i(STA), .rx_deliver_en_o(deliver), .wake_event_o(wake));
    wfd_rx_model i_rx (.clk_i(clk_i), .rx_sof_o(sof), .rx_valid_o(vld), .rx_data_o(rxd),
        .rx_eof_o(eof), .rx_fcs_ok_o(fok), .rx_addr_pass_o(apass));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask : bus
    task automatic load(input logic [3:0] cmd);
        logic [31:0] w [8];
        w = '{{1'b0, MASK}, 0, 0, 0, {28'h0, cmd}, 32'h0000_000e, {16'h0, ecrc}, 0};
        for (int i = 0; i < 8; i++) bus(1'b1, WFD_STORE_OFS, w[i]);
        bus(1'b0, WFD_INFO_OFS, 32'h0);
        chk("store pointer", rd & 32'h7, 32'h0);
        bus(1'b0, WFD_STORE_OFS, 32'h0);
        chk("store word", rd, {1'b0, MASK});
    endtask : load
    task automatic hdr(input logic [47:0] da);
        for (int i = 0; i < 64; i++) i_rx.fb[i] = i[7:0];
        for (int i = 0; i < 6; i++) i_rx.fb[i] = da[47-8*i -: 8];
        wp = 14;
    endtask : hdr
    task automatic app(input logic [47:0] v, input int k);
        for (int i = 0; i < 6 * k; i++) begin
            i_rx.fb[wp] = v[47-8*(i%6) -: 8];
            wp++;
        end
    endtask : app
    // reference crc over masked bytes from offset 14, reflected and seeded all ones
    function automatic logic [15:0] crc_of();
        logic [15:0] c;
        c = 16'hffff;
        for (int j = 0; j < 31; j++) begin
            if (MASK[j]) begin
                c = c ^ {8'h00, i_rx.fb[14+j]};
                for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction : crc_of
    task automatic wake_case(input logic [47:0] da, input logic g, input logic p,
        input logic at, input logic en, input logic f, input int flip, input logic exp);
        int n;
        hdr(da);
        ecrc = crc_of();
        load({at, 2'b00, en});
        bus(1'b1, WFD_CSR_OFS, {22'h0, g, 9'h004});
        // the write lands at the edge the bus task returns on
        @(posedge clk_i);
        chk("deliver off", deliver, 1'b0);
        if (flip != 0) i_rx.fb[flip] ^= 8'h01;
        n = wakes;
        i_rx.send(64, f, p, flip != 0);
        repeat (3) @(posedge clk_i);
        chk("wake pulses", wakes - n, exp);
        bus(1'b0, WFD_CSR_OFS, 32'h0);
        chk("wake status", rd[5], exp);
        bus(1'b0, WFD_INFO_OFS, 32'h0);
        chk("hit filters", rd[11:8], 4'h1);
        bus(1'b1, WFD_CSR_OFS, 32'h20);
        bus(1'b0, WFD_CSR_OFS, 32'h0);
        chk("deliver back", deliver, 1'b1);
    endtask : wake_case
    task automatic magic_case(input logic [47:0] da, input logic sync, input int n1,
        input logic brk, input int n2, input logic irq, input logic exp);
        int n;
        hdr(da);
        if (sync) app(BC, 1);
        app(STA, n1);
        if (brk) begin
            i_rx.fb[wp] = 8'h00;
            wp++;
            app(BC, 1);
            app(STA, n2);
        end
        bus(1'b1, WFD_CSR_OFS, {28'h0, irq, 3'b010});
        @(posedge clk_i);
        chk("deliver off", deliver, 1'b0);
        n = wakes;
        i_rx.send(wp, 1'b1, 1'b1, brk);
        repeat (3) @(posedge clk_i);
        chk("magic wake", wakes - n, exp && irq);
        bus(1'b0, WFD_CSR_OFS, 32'h0);
        chk("magic status", rd[4], exp);
        bus(1'b1, WFD_CSR_OFS, 32'h10);
        bus(1'b0, WFD_CSR_OFS, 32'h0);
        chk("deliver back", deliver, 1'b1);
    endtask : magic_case
    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, WFD_CSR_OFS, 32'h0);
        chk("csr reset", rd, WFD_CSR_RST);
        bus(1'b1, 8'h0c, 32'hffff_ffff);
        bus(1'b0, 8'h0c, 32'h0);
        chk("unmapped", rd, 32'h0);
        wake_case(BC, 0, 0, 1, 1, 1, 0, 1);
        wake_case(STA, 1, 0, 1, 1, 1, 0, 1);
        wake_case(STA, 0, 0, 0, 1, 1, 0, 0);
        wake_case(STA, 0, 1, 0, 1, 1, 0, 1);
        wake_case(STA, 0, 1, 1, 1, 1, 0, 0);
        wake_case(MC, 0, 1, 1, 1, 1, 0, 1);
        wake_case(MC, 1, 0, 1, 1, 1, 0, 0);
        wake_case(MC, 0, 1, 0, 1, 1, 0, 0);
        wake_case(BC, 0, 0, 1, 0, 1, 0, 0);
        wake_case(BC, 0, 0, 1, 1, 0, 0, 0);
        wake_case(BC, 0, 0, 1, 1, 1, 16, 0);
        wake_case(BC, 0, 0, 1, 1, 1, 15, 1);
        magic_case(STA, 1, 16, 0, 0, 1, 1);
        magic_case(BC, 1, 16, 0, 0, 1, 1);
        magic_case(MC, 1, 16, 0, 0, 1, 1);
        magic_case(48'h0200_0000_0009, 1, 16, 0, 0, 1, 0);
        magic_case(STA, 1, 15, 1, 16, 1, 1);
        magic_case(STA, 0, 16, 0, 0, 1, 0);
        magic_case(STA, 1, 15, 1, 0, 1, 0);
        magic_case(STA, 1, 16, 0, 0, 0, 1);
        test_done;
    end
    initial begin
        #100000;
        failures++;
        test_done;
    end
    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
endmodule : tb_top
`default_nettype wire
